/* File: design/scanner_consts.vh */
// Purpose: Offsets, field positions, reset values and widths for the memory scanner.
// Assumes: Included by the scanner design file and by the port checker.
// Notes:   Byte registers sit in the low bits of aligned 32-bit words.
`ifndef SCANNER_CONSTS_VH
`define SCANNER_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define OFS_SHIFT_LOW    8'h00
`define OFS_POLY_HIGH    8'h04
`define OFS_POLY_LOW     8'h08
`define OFS_CONTROL      8'h0C
`define OFS_CUR_UPPER    8'h10
`define OFS_CUR_HIGH     8'h14
`define OFS_CUR_LOW      8'h18
`define OFS_END_UPPER    8'h1C
`define OFS_END_HIGH     8'h20
`define OFS_END_LOW      8'h24
`define OFS_TRIG_SEL     8'h28
`define OFS_FLAGS        8'h2C

// ****************************************
// Control register fields
// ****************************************
`define CTL_ENABLE       7
`define CTL_TRIG_ON      6
`define CTL_GO           5
`define CTL_REGION       2
`define CTL_BURST        1
`define CTL_BUSY         0
`define CTL_WR_MASK      8'hC6

// ****************************************
// Widths and reset values
// ****************************************
`define ADDR_W           22
`define CUR_RESET        22'h000000
`define END_RESET        22'h3FFFFF
`define TRIG_W           4
`define TRIG_N           16
`define WORD_W           16

`endif

/* File: design/memory_scanner_crc_feed.v */
// Purpose: Memory scanner feeding words from flash or EEPROM to the CRC engine.
// Assumes: AHB-Lite single word transfers; memory answers a granted fetch with mem_rvalid.
// Notes:   Trigger inputs come from other clock domains and are synchronised here.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "scanner_consts.vh"

module memory_scanner_crc_feed (
   input  wire                  hclk,
   input  wire                  hresetn,
   input  wire                  hsel,
   input  wire [7:0]            haddr,
   input  wire [1:0]            htrans,
   input  wire                  hwrite,
   input  wire [2:0]            hsize,
   input  wire [31:0]           hwdata,
   input  wire                  hready,
   output wire                  hreadyout,
   output wire                  hresp,
   output reg  [31:0]           hrdata,
   input  wire                  crc_on,
   input  wire                  crc_run,
   input  wire                  crc_ready,
   input  wire [15:0]           crc_shifter,
   output wire [15:0]           crc_poly_terms,
   output reg  [15:0]           crc_data,
   output reg                   crc_data_valid,
   input  wire [15:0]           trigger_in,
   output wire                  mem_req,
   input  wire                  mem_grant,
   input  wire                  mem_rvalid,
   input  wire [15:0]           mem_rdata,
   output wire [21:0]           mem_addr,
   output wire                  region_select,
   output wire                  block_lower,
   output reg                   scan_done_flag
);

   // ****************************************
   // State machine
   // ****************************************
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_REQ   = 3'b010;
   localparam [2:0] ST_WAIT  = 3'b100;

   reg  [2:0]            state_r;
   reg  [2:0]            state_nxt;
   reg                   enable_r;
   reg                   trigger_gate_on;
   reg                   scan_go;
   reg                   region_r;
   reg                   burst_request;
   reg  [21:0]           current_scan_address;
   reg  [21:0]           end_scan_address;
   reg  [3:0]            trigger_source_select;
   reg  [15:0]           trig_meta_r;
   reg  [15:0]           trig_sync_r;
   reg                   wr_pend_r;
   reg  [15:1]           poly_r;
   reg  [7:0]            addr_r;

   wire                  fetch_done;
   wire                  past_end;
   wire                  trig_true;
   wire                  busy;
   wire                  wr_ctl;
   wire                  wr_poly_high;
   wire                  wr_poly_low;
   wire                  wr_cur_upper;
   wire                  wr_cur_high;
   wire                  wr_cur_low;
   wire                  wr_end_upper;
   wire                  wr_end_high;
   wire                  wr_end_low;
   wire                  wr_trig_sel;
   wire                  wr_flags;

   // ****************************************
   // Helpers
   // ****************************************
   function [7:0] byte_of;
      input [21:0] value;
      input [1:0]  sel;
      begin
         case (sel)
            2'd2:    byte_of = {2'b00, value[21:16]};
            2'd1:    byte_of = value[15:8];
            default: byte_of = value[7:0];
         endcase
      end
   endfunction

   function [21:0] put_byte;
      input [21:0] value;
      input [1:0]  sel;
      input [7:0]  data;
      begin
         put_byte = value;
         case (sel)
            2'd2:    put_byte[21:16] = data[5:0];
            2'd1:    put_byte[15:8]  = data;
            default: put_byte[7:0]   = data;
         endcase
      end
   endfunction

   // ****************************************
   // Trigger synchroniser and selection
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_meta_r <= 16'h0000;
         trig_sync_r <= 16'h0000;
      end else begin
         trig_meta_r <= trigger_in;
         trig_sync_r <= trig_meta_r;
      end
   end

   assign trig_true = trig_sync_r[trigger_source_select];

   // ****************************************
   // Scan sequencer
   // ****************************************
   assign fetch_done = (state_r == ST_WAIT) && mem_rvalid;
   assign past_end   = current_scan_address > end_scan_address;
   assign busy       = enable_r && (state_r != ST_IDLE);
   assign mem_addr   = current_scan_address;
   assign region_select = region_r;
   assign block_lower = enable_r && scan_go && burst_request;

   assign mem_req = enable_r && scan_go && !past_end && (state_r != ST_WAIT) &&
                    (burst_request || (crc_ready && (!trigger_gate_on || trig_true)));

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (mem_req && mem_grant) state_nxt = ST_WAIT;
            else if (mem_req)         state_nxt = ST_REQ;
         end
         ST_REQ: begin
            if (mem_req && mem_grant) state_nxt = ST_WAIT;
            else if (!mem_req)        state_nxt = ST_IDLE;
         end
         ST_WAIT: begin
            if (mem_rvalid) state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (!enable_r && state_r != ST_WAIT) state_nxt = ST_IDLE;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r        <= ST_IDLE;
         crc_data       <= 16'h0000;
         crc_data_valid <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         crc_data_valid <= fetch_done;
         if (fetch_done) crc_data <= mem_rdata;
      end
   end

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_ctl       = wr_pend_r && (addr_r == `OFS_CONTROL);
   assign wr_poly_high = wr_pend_r && (addr_r == `OFS_POLY_HIGH);
   assign wr_poly_low  = wr_pend_r && (addr_r == `OFS_POLY_LOW);
   assign wr_cur_upper = wr_pend_r && (addr_r == `OFS_CUR_UPPER);
   assign wr_cur_high  = wr_pend_r && (addr_r == `OFS_CUR_HIGH);
   assign wr_cur_low   = wr_pend_r && (addr_r == `OFS_CUR_LOW);
   assign wr_end_upper = wr_pend_r && (addr_r == `OFS_END_UPPER);
   assign wr_end_high  = wr_pend_r && (addr_r == `OFS_END_HIGH);
   assign wr_end_low   = wr_pend_r && (addr_r == `OFS_END_LOW);
   assign wr_trig_sel  = wr_pend_r && (addr_r == `OFS_TRIG_SEL);
   assign wr_flags     = wr_pend_r && (addr_r == `OFS_FLAGS);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         addr_r    <= haddr;
      end
   end

   // Polynomial terms hold no reset, matching an unknown power-up value
   always @(posedge hclk) begin
      if (wr_poly_high) poly_r[15:8] <= hwdata[7:0];
      if (wr_poly_low)  poly_r[7:1]  <= hwdata[7:1];
   end

   assign crc_poly_terms = {poly_r, 1'b1};

   // ****************************************
   // Control register
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_r        <= 1'b0;
         trigger_gate_on <= 1'b0;
         region_r        <= 1'b0;
         burst_request   <= 1'b0;
      end else if (wr_ctl) begin
         enable_r        <= hwdata[`CTL_ENABLE];
         trigger_gate_on <= hwdata[`CTL_TRIG_ON];
         region_r        <= hwdata[`CTL_REGION];
         burst_request   <= hwdata[`CTL_BURST];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_go <= 1'b0;
      end else if (!crc_run || (past_end && state_r != ST_WAIT)) begin
         scan_go <= 1'b0;
      end else if (wr_ctl) begin
         scan_go <= hwdata[`CTL_GO];
      end
   end

   // ****************************************
   // Scan addresses
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         current_scan_address <= `CUR_RESET;
      end else if (fetch_done) begin
         current_scan_address <= current_scan_address + 22'h000001;
      end else if (!scan_go) begin
         if (wr_cur_upper) begin
            current_scan_address <= put_byte(current_scan_address, 2'd2, hwdata[7:0]);
         end else if (wr_cur_high) begin
            current_scan_address <= put_byte(current_scan_address, 2'd1, hwdata[7:0]);
         end else if (wr_cur_low) begin
            current_scan_address <= put_byte(current_scan_address, 2'd0, hwdata[7:0]);
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         end_scan_address <= `END_RESET;
      end else if (!scan_go) begin
         if (wr_end_upper) begin
            end_scan_address <= put_byte(end_scan_address, 2'd2, hwdata[7:0]);
         end else if (wr_end_high) begin
            end_scan_address <= put_byte(end_scan_address, 2'd1, hwdata[7:0]);
         end else if (wr_end_low) begin
            end_scan_address <= put_byte(end_scan_address, 2'd0, hwdata[7:0]);
         end
      end
   end

   // ****************************************
   // Trigger select and done flag
   // ****************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trigger_source_select <= 4'h0;
      end else if (wr_trig_sel) begin
         trigger_source_select <= hwdata[3:0];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_done_flag <= 1'b0;
      end else if (fetch_done && current_scan_address == end_scan_address) begin
         scan_done_flag <= 1'b1;
      end else if (wr_flags && hwdata[0]) begin
         scan_done_flag <= 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= 32'h00000000;
         if (haddr == `OFS_SHIFT_LOW)
            hrdata[7:0] <= crc_shifter[7:0];
         else if (haddr == `OFS_POLY_HIGH)
            hrdata[7:0] <= crc_poly_terms[15:8];
         else if (haddr == `OFS_POLY_LOW)
            hrdata[7:0] <= {crc_poly_terms[7:1], 1'b1};
         else if (haddr == `OFS_CONTROL)
            hrdata[7:0] <= {enable_r, trigger_gate_on, scan_go, 2'b00,
                            region_r, burst_request, busy};
         else if (haddr == `OFS_CUR_UPPER)
            hrdata[7:0] <= byte_of(current_scan_address, 2'd2);
         else if (haddr == `OFS_CUR_HIGH)
            hrdata[7:0] <= byte_of(current_scan_address, 2'd1);
         else if (haddr == `OFS_CUR_LOW)
            hrdata[7:0] <= byte_of(current_scan_address, 2'd0);
         else if (haddr == `OFS_END_UPPER)
            hrdata[7:0] <= byte_of(end_scan_address, 2'd2);
         else if (haddr == `OFS_END_HIGH)
            hrdata[7:0] <= byte_of(end_scan_address, 2'd1);
         else if (haddr == `OFS_END_LOW)
            hrdata[7:0] <= byte_of(end_scan_address, 2'd0);
         else if (haddr == `OFS_TRIG_SEL)
            hrdata[7:0] <= {4'h0, trigger_source_select};
         else if (haddr == `OFS_FLAGS)
            hrdata[7:0] <= {7'h00, scan_done_flag};
      end
   end

endmodule

/* File: testbench/scan_mem_model.sv */
// Purpose: Memory and arbiter partner for the scanner's fetch port.
// Assumes: One outstanding fetch; grant whenever asked.
// Notes:   Slow mode answers eight cycles late; data toggles when idle.
`timescale 1ns/100ps
module scan_mem_model (
   input  logic        hclk,
   input  logic        hresetn,
   input  logic        slow,
   input  logic        mem_req,
   input  logic [21:0] mem_addr,
   input  logic        region_select,
   output logic        mem_grant,
   output logic        mem_rvalid,
   output logic [15:0] mem_rdata
);
   logic [3:0] wait_cnt;
   logic       pend;
   assign mem_grant = mem_req && !pend;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= 1'b0;
         wait_cnt <= 4'h0;
         mem_rvalid <= 1'b0;
         mem_rdata <= 16'h0000;
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_grant) begin
            pend <= 1'b1;
            wait_cnt <= slow ? 4'h8 : 4'h0;
         end else if (pend && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end else if (pend) begin
            pend <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata <= {region_select, mem_addr[14:0]};
         end
      end
   end
endmodule

/* File: testbench/scan_feed_sva.sv */
// Purpose: Port checker for the memory scanner.
// Assumes: Zero wait bus slave.
// Notes:   Register accesses are seen only through bus traffic; done flag, poly terms and address at their ports.
`timescale 1ns/100ps
`include "scanner_consts.vh"
module scan_feed_sva (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [7:0]  haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   input wire        crc_run,
   input wire        crc_ready,
   input wire [15:0] crc_shifter,
   input wire [15:0] crc_poly_terms,
   input wire [15:0] crc_data,
   input wire        crc_data_valid,
   input wire        mem_req,
   input wire        mem_grant,
   input wire        mem_rvalid,
   input wire [15:0] mem_rdata,
   input wire [21:0] mem_addr,
   input wire        block_lower,
   input wire        scan_done_flag
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire  a_ph = hsel && hready && htrans[1];
   logic rd_shift_r, wr_flag_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_shift_r <= 1'b0;
         wr_flag_r <= 1'b0;
      end else begin
         rd_shift_r <= a_ph && !hwrite && haddr == `OFS_SHIFT_LOW;
         wr_flag_r <= a_ph && hwrite && haddr == `OFS_FLAGS;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   sequence fetch_taken;
      mem_req && mem_grant;
   endsequence
   sequence word_back;
      mem_rvalid ##1 crc_data_valid;
   endsequence
   AST_BUS: assert property (hreadyout && !hresp) else $error("bus answer not ready OKAY");
   AST_REQ_READY: assert property (mem_req && !block_lower |-> crc_ready)
      else $error("request without ready CRC");
   AST_RUN_STOP: assert property (!crc_run |=> !mem_req) else $error("request after run low");
   AST_DATA: assert property (word_back |-> crc_data == $past(mem_rdata))
      else $error("CRC word differs from memory word");
   AST_ADDR: assert property (crc_data_valid |-> mem_addr == $past(mem_addr) + 22'h1)
      else $error("address not stepped by one");
   AST_ONE_OUT: assert property (fetch_taken |=> !mem_req) else $error("second fetch pending");
   AST_POLY0: assert property (crc_poly_terms[0]) else $error("poly bit zero not one");
   AST_SHIFT: assert property (rd_shift_r |-> hrdata == {24'h000000, $past(crc_shifter[7:0])})
      else $error("shifter byte read wrong");
   AST_FLAG: assert property (scan_done_flag && !wr_flag_r |=> scan_done_flag)
      else $error("done flag lost");
   AST_BURST: assert property ($rose(block_lower) |-> mem_req) else $error("burst not requesting");
endmodule
bind memory_scanner_crc_feed scan_feed_sva scan_feed_sva_i (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .crc_run, .crc_ready, .crc_shifter,
   .crc_poly_terms, .crc_data, .crc_data_valid, .mem_req, .mem_grant, .mem_rvalid, .mem_rdata,
   .mem_addr, .block_lower, .scan_done_flag);

/* File: testbench/memory_scanner_crc_feed_test.sv */
// Purpose: Self-checking bench for the memory scanner.
// Assumes: Partner returns region bit over address bits 14..0.
// Notes:   Register table rows first, then scan scenarios.
`timescale 1ns/100ps
module memory_scanner_crc_feed_test;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, crc_on = 1'b1;
   logic        crc_run = 1'b0, crc_ready = 1'b0, slow = 1'b1, exp_r = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h0, rdata;
   logic [15:0] crc_shifter = 16'hA5C3, trigger_in = 16'h0000;
   logic [21:0] exp_a = 22'h0;
   wire         hready, hreadyout, hresp, crc_data_valid, mem_req, mem_grant, mem_rvalid;
   wire         region_select, block_lower, scan_done_flag;
   wire [31:0]  hrdata;
   wire [15:0]  crc_poly_terms, crc_data, mem_rdata;
   wire [21:0]  mem_addr;
   integer      mismatches = 0, checks_done = 0, cyc = 0;
   logic [24:0] rows [17] = '{
      {1'b0,8'h00,8'h00,8'hC3}, {1'b0,8'h0C,8'h00,8'h00}, {1'b0,8'h10,8'h00,8'h00},
      {1'b0,8'h14,8'h00,8'h00}, {1'b0,8'h18,8'h00,8'h00}, {1'b0,8'h1C,8'h00,8'h3F},
      {1'b0,8'h20,8'h00,8'hFF}, {1'b0,8'h24,8'h00,8'hFF}, {1'b0,8'h28,8'h00,8'h00},
      {1'b0,8'h2C,8'h00,8'h00}, {1'b1,8'h00,8'hFF,8'hC3}, {1'b1,8'h08,8'h00,8'h01},
      {1'b1,8'h08,8'hFF,8'hFF}, {1'b1,8'h04,8'h5A,8'h5A}, {1'b1,8'h10,8'hFF,8'h3F},
      {1'b1,8'h30,8'hFF,8'h00}, {1'b1,8'h28,8'h1F,8'h0F}};
   assign hready = hreadyout;
   memory_scanner_crc_feed memory_scanner_crc_feed_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .crc_on, .crc_run,
      .crc_ready, .crc_shifter, .crc_poly_terms, .crc_data, .crc_data_valid, .trigger_in,
      .mem_req, .mem_grant, .mem_rvalid, .mem_rdata, .mem_addr, .region_select, .block_lower,
      .scan_done_flag);
   scan_mem_model scan_mem_model_i (.hclk, .hresetn, .slow, .mem_req, .mem_addr, .region_select,
      .mem_grant, .mem_rvalid, .mem_rdata);
   always #2.5 hclk = ~hclk;
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done = checks_done + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rdata = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(rdata, e);
   endtask
   task automatic setup(input logic [21:0] c, input logic [21:0] h);
      xfer(8'h10, 1'b1, 32'(c[21:16]));
      xfer(8'h14, 1'b1, 32'(c[15:8]));
      xfer(8'h18, 1'b1, 32'(c[7:0]));
      xfer(8'h1C, 1'b1, 32'(h[21:16]));
      xfer(8'h20, 1'b1, 32'(h[15:8]));
      xfer(8'h24, 1'b1, 32'(h[7:0]));
      exp_a = c;
   endtask
   task automatic wait_done;
      repeat (300) if (scan_done_flag !== 1'b1) @(posedge hclk);
      xfer(8'h2C, 1'b1, 32'h1);
   endtask
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (crc_data_valid === 1'b1) begin
         chk(32'(crc_data), 32'({exp_r, exp_a[14:0]}));
         exp_a = exp_a + 22'h1;
      end
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         conclude;
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i][24]) xfer(rows[i][23:16], 1'b1, 32'(rows[i][15:8]));
         rd(rows[i][23:16], 32'(rows[i][7:0]));
      end
      chk(32'(crc_poly_terms), 32'h5AFF);
      $display("register rows done");
      crc_run <= 1'b1;
      crc_ready <= 1'b1;
      setup(22'h000010, 22'h000012);
      xfer(8'h0C, 1'b1, 32'hA0);
      xfer(8'h18, 1'b1, 32'h00);
      xfer(8'h24, 1'b1, 32'h10);
      rd(8'h0C, 32'hA1);
      wait_done;
      chk(32'(mem_addr), 32'h13);
      chk(32'(exp_a), 32'h13);
      rd(8'h0C, 32'h80);
      rd(8'h2C, 32'h00);
      $display("plain scan done");
      crc_ready <= 1'b0;
      slow <= 1'b0;
      exp_r = 1'b1;
      setup(22'h000020, 22'h000021);
      xfer(8'h0C, 1'b1, 32'hA6);
      @(posedge hclk);
      chk(32'(block_lower), 32'h1);
      chk(32'(region_select), 32'h1);
      wait_done;
      chk(32'(exp_a), 32'h22);
      chk(32'(block_lower), 32'h0);
      $display("burst scan done");
      setup(22'h000030, 22'h000031);
      xfer(8'h28, 1'b1, 32'h3);
      xfer(8'h0C, 1'b1, 32'hA0);
      exp_r = 1'b0;
      repeat (20) @(posedge hclk);
      chk(32'(exp_a), 32'h30);
      xfer(8'h0C, 1'b1, 32'hE0);
      crc_ready <= 1'b1;
      repeat (20) @(posedge hclk);
      chk(32'(exp_a), 32'h30);
      trigger_in <= 16'h0008;
      wait_done;
      chk(32'(exp_a), 32'h32);
      $display("trigger scan done");
      crc_ready <= 1'b0;
      setup(22'h000040, 22'h00004F);
      xfer(8'h0C, 1'b1, 32'hA0);
      crc_run <= 1'b0;
      repeat (4) @(posedge hclk);
      rd(8'h0C, 32'h80);
      crc_run <= 1'b1;
      crc_ready <= 1'b1;
      xfer(8'h0C, 1'b1, 32'h26);
      repeat (20) @(posedge hclk);
      chk(32'(exp_a), 32'h40);
      chk(32'(mem_req), 32'h0);
      rd(8'h0C, 32'h26);
      $display("stop scan done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk(32'(mem_addr), 32'h0);
      rd(8'h0C, 32'h00);
      rd(8'h24, 32'hFF);
      $display("reset test done");
      conclude;
   end
endmodule
